// file: iew_core_model.sv
// Behavioural model of the processor core that faces the interrupt block
`timescale 1ns/100ps
module iew_core_model (
  // Clock and reset
  input  wire logic       clk_in,
  input  wire logic       rst_b_in,
  // Cycles between instruction completions, minus one
  input  wire logic [3:0] gap_in,
  // Forced call from the block
  input  wire logic       lcall_in,
  // Instruction stream towards the block
  output logic            instr_end_out,
  output logic            reti_out
);
  logic [3:0] cnt;
  logic [3:0] isr_left;
  logic       in_isr;

  // One instruction ends every gap_in+1 cycles; a short service ends by return
  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      cnt           <= 4'h0;
      isr_left      <= 4'h0;
      in_isr        <= 1'b0;
      instr_end_out <= 1'b0;
      reti_out      <= 1'b0;
    end else begin
      instr_end_out <= 1'b0;
      reti_out      <= 1'b0;
      if (lcall_in) begin
        in_isr   <= 1'b1;
        isr_left <= 4'h4;
      end
      if (cnt >= gap_in) begin
        cnt           <= 4'h0;
        instr_end_out <= 1'b1;
        // Return only after a few handler instructions, never in the call cycle
        if (in_isr && !lcall_in) begin
          if (isr_left == 4'h0) begin
            reti_out <= 1'b1;
            in_isr   <= 1'b0;
          end else begin
            isr_left <= isr_left - 4'h1;
          end
        end
      end else begin
        cnt <= cnt + 4'h1;
      end
    end
  end
endmodule

// file: iew_pkg.sv
// Package for the interrupt enable and watchdog refresh block
package iew_pkg;
  // Special function register addresses (8-bit SFR space, chosen here)
  localparam logic [7:0] ADDR_TIMER_AND_EXT_IRQ_CONTROL_REG   = 8'h88;
  localparam logic [7:0] ADDR_IEN_LOW    = 8'hA8;
  localparam logic [7:0] ADDR_IEN_EXTRA  = 8'h9A;
  localparam logic [7:0] ADDR_PRIO_ZERO  = 8'hA9;
  localparam logic [7:0] ADDR_PRIO_ONE   = 8'hB9;
  localparam logic [7:0] ADDR_IEN_HIGH   = 8'hB8;
  localparam logic [7:0] ADDR_IRQ_REQ    = 8'hC0;
  localparam logic [7:0] ADDR_WD_RELOAD  = 8'h86;
  // Field positions
  localparam int POS_GLOBAL_EN   = 7;
  localparam int POS_WD_REFRESH  = 6;
  localparam int POS_WD_START    = 6;
  localparam int POS_WD_STATUS   = 6;
  localparam int POS_WD_PRESCALE = 7;
  localparam int POS_TB_OVF      = 7;
  localparam int POS_TA_OVF      = 5;
  localparam int POS_XB_FLAG     = 3;
  localparam int POS_XB_TYPE     = 2;
  localparam int POS_XA_FLAG     = 1;
  localparam int POS_XA_TYPE     = 0;
  // Reset value of every register
  localparam logic [7:0] REG_RESET = 8'h00;
  // Watchdog timing
  localparam int CLK_MHZ          = 250;
  localparam int FLAG_LIFE_CYC    = 12;
  localparam int WD_TICK_FAST     = 24;
  localparam int WD_TICK_SLOW     = 384;
  localparam logic [15:0] WD_TRIP = 16'h7CFF;
  // Number of interrupt sources
  localparam int NUM_SRC = 11;
  // Acknowledge sequencer states
  typedef enum logic [1:0] {IEW_IDLE, IEW_PEND, IEW_ACK} iew_ack_t;
endpackage

// file: iew_prio_mem.sv
// Small memory holding the in-service level stack of the interrupt logic
`timescale 1ns/100ps
module iew_prio_mem (
  // Clock
  input  wire logic       clk_in,
  input  wire logic       en_in,
  // Write port
  input  wire logic       wr_in,
  input  wire logic [1:0] wr_addr_in,
  input  wire logic [2:0] wr_data_in,
  // Read port
  input  wire logic [1:0] rd_addr_in,
  output logic      [2:0] rd_data_out
);
  logic [2:0] mem [4];

  // Registered read keeps the level compare off the write path
  always_ff @(posedge clk_in) begin
    if (en_in) begin
      if (wr_in) begin
        mem[wr_addr_in] <= wr_data_in;
      end
      rd_data_out <= mem[rd_addr_in];
    end
  end
endmodule

// file: iew_top.sv
// Interrupt enable, flag, acknowledge and software watchdog logic
`timescale 1ns/100ps
module iew_top (
  // Clock, enable and reset
  input  wire logic        clk_sys_in,
  input  wire logic        clk_en_in,
  input  wire logic        rst_b_in,
  // Special function register port
  input  wire logic        sfr_wr_in,
  input  wire logic        sfr_rd_in,
  input  wire logic [7:0]  sfr_addr_in,
  input  wire logic [7:0]  sfr_wdata_in,
  output logic      [7:0]  sfr_rdata_out,
  // Core handshake
  input  wire logic        instr_end_in,
  input  wire logic        reti_in,
  output logic             lcall_out,
  output logic      [3:0]  lcall_src_out,
  // Interrupt event inputs
  input  wire logic        timer_a_ovf_in,
  input  wire logic        timer_b_ovf_in,
  input  wire logic        serial_a_irq_in,
  input  wire logic        serial_b_irq_in,
  input  wire logic        ext_line_a_b_in,
  input  wire logic        ext_line_b_b_in,
  input  wire logic [4:0]  ext_line_cg_in,
  // Watchdog outputs
  output logic             wd_reset_req_out,
  output logic      [15:0] wd_count_out
);
  typedef struct packed {
    logic [7:0]        ien_low;
    logic [7:0]        ien_high;
    logic [7:0]        ien_extra;
    logic [5:0]        prio0;
    logic [5:0]        prio1;
    logic [7:0]        timer_and_ext_irq_control_flags;
    logic [4:0]        ext_flags;
    logic [1:0]        ser_flags;
    logic [7:0]        wd_reload;
    logic [3:0]        refresh_cnt;
    logic [3:0]        start_cnt;
    logic              wd_run;
    logic              wd_status;
    logic [15:0]       wd_cnt;
    logic [8:0]        wd_pre;
    logic [1:0]        ext_ab_last;
    logic [4:0]        ext_cg_last;
    logic [10:0]       sample;
    iew_pkg::iew_ack_t ack_st;
    logic [3:0]        ack_src;
    logic [2:0]        cur_lvl;
    logic [1:0]        depth;
    logic              lcall;
    logic [7:0]        rdata;
  } iew_state_t;

  iew_state_t st;
  iew_state_t next_st;
  logic       rst_m;
  logic       rst_s;
  logic       mem_wr;
  logic [1:0] mem_waddr;
  logic [2:0] mem_wdata;
  logic [2:0] mem_rdata;

  // Release reset through two flops so removal is clean
  always_ff @(posedge clk_sys_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      rst_m <= 1'b0;
      rst_s <= 1'b0;
    end else begin
      rst_m <= 1'b1;
      rst_s <= rst_m;
    end
  end

  // Priority level of a source: group bit from each priority register
  function automatic logic [1:0] src_level(input logic [3:0] s, input logic [5:0] p0,
                                           input logic [5:0] p1);
    logic [2:0] g;
    g = (s > 4'h5) ? 3'(s - 4'h6) : s[2:0];
    src_level = {p1[g], p0[g]};
  endfunction

  // Enable per source, index order: xa,ta,xb,tb,sa,sb,xc..xg
  function automatic logic [10:0] src_enables(input iew_state_t x);
    src_enables = {x.ien_high[5:1], x.ien_extra[0], x.ien_low[4:0]};
  endfunction

  // Raw request flags in the same order
  function automatic logic [10:0] src_flags(input iew_state_t x);
    src_flags = {x.ext_flags, x.ser_flags[1], x.ser_flags[0],
                 x.timer_and_ext_irq_control_flags[iew_pkg::POS_TB_OVF], x.timer_and_ext_irq_control_flags[iew_pkg::POS_XB_FLAG],
                 x.timer_and_ext_irq_control_flags[iew_pkg::POS_TA_OVF], x.timer_and_ext_irq_control_flags[iew_pkg::POS_XA_FLAG]};
  endfunction

  logic [10:0] ready;
  logic [3:0]  best_src;
  logic [1:0]  best_lvl;
  logic        best_ok;
  logic        ack_block;

  // Poll sampled flags: highest level, lowest index wins
  always_comb begin
    ready    = st.sample & src_enables(st);
    best_src = 4'h0;
    best_lvl = 2'h0;
    best_ok  = 1'b0;
    for (int i = 0; i < iew_pkg::NUM_SRC; i++) begin
      if (ready[i] && (!best_ok || src_level(4'(i), st.prio0, st.prio1) > best_lvl)) begin
        best_ok  = 1'b1;
        best_src = 4'(i);
        best_lvl = src_level(4'(i), st.prio0, st.prio1);
      end
    end
    ack_block = reti_in || (sfr_wr_in && (sfr_addr_in == iew_pkg::ADDR_IEN_LOW ||
                sfr_addr_in == iew_pkg::ADDR_IEN_HIGH || sfr_addr_in == iew_pkg::ADDR_IEN_EXTRA ||
                sfr_addr_in == iew_pkg::ADDR_PRIO_ZERO || sfr_addr_in == iew_pkg::ADDR_PRIO_ONE));
  end

  // Next state of everything
  always_comb begin
    logic       tick;
    logic [8:0] pre_lim;
    logic [3:0] a;
    tick      = 1'b0;
    pre_lim   = 9'h000;
    a         = 4'h0;
    next_st   = st;
    mem_wr    = 1'b0;
    mem_waddr = st.depth;
    mem_wdata = st.cur_lvl;
    next_st.lcall = 1'b0;
    next_st.ext_ab_last = {ext_line_b_b_in, ext_line_a_b_in};
    next_st.ext_cg_last = ext_line_cg_in;
    // Self-clearing watchdog control flags; a write below may restart them
    if (st.refresh_cnt != 4'h0) begin
      next_st.refresh_cnt = st.refresh_cnt - 4'h1;
    end
    if (st.start_cnt != 4'h0) begin
      next_st.start_cnt = st.start_cnt - 4'h1;
    end
    // Software writes first; hardware set events further down win over them
    if (sfr_wr_in) begin
      case (sfr_addr_in)
        iew_pkg::ADDR_IEN_LOW:   next_st.ien_low  = sfr_wdata_in & 8'hBF;
        iew_pkg::ADDR_IEN_HIGH:  next_st.ien_high = sfr_wdata_in & 8'hBF;
        iew_pkg::ADDR_IEN_EXTRA: next_st.ien_extra = sfr_wdata_in;
        iew_pkg::ADDR_PRIO_ZERO: next_st.prio0 = sfr_wdata_in[5:0];
        iew_pkg::ADDR_PRIO_ONE:  next_st.prio1 = sfr_wdata_in[5:0];
        iew_pkg::ADDR_TIMER_AND_EXT_IRQ_CONTROL_REG:  next_st.timer_and_ext_irq_control_flags = sfr_wdata_in;
        iew_pkg::ADDR_IRQ_REQ:   next_st.ext_flags = sfr_wdata_in[5:1];
        iew_pkg::ADDR_WD_RELOAD: next_st.wd_reload = sfr_wdata_in;
        default: ;
      endcase
      // Refresh and start flags are set by writing one
      if (sfr_addr_in == iew_pkg::ADDR_IEN_LOW && sfr_wdata_in[iew_pkg::POS_WD_REFRESH]) begin
        next_st.refresh_cnt = 4'(iew_pkg::FLAG_LIFE_CYC);
      end
      if (sfr_addr_in == iew_pkg::ADDR_IEN_HIGH && sfr_wdata_in[iew_pkg::POS_WD_START]) begin
        next_st.start_cnt = 4'(iew_pkg::FLAG_LIFE_CYC);
        next_st.wd_run    = 1'b1;
        if (st.refresh_cnt != 4'h0) begin
          next_st.wd_cnt = {1'b0, st.wd_reload[6:0], 8'h00};
          next_st.wd_pre = 9'h000;
          next_st.refresh_cnt = 4'h0;
        end
      end
    end
    // Watchdog counter; prescaler by 24 or by 384
    pre_lim = st.wd_reload[iew_pkg::POS_WD_PRESCALE] ?
              9'(iew_pkg::WD_TICK_SLOW - 1) : 9'(iew_pkg::WD_TICK_FAST - 1);
    tick = st.wd_run && (st.wd_pre == pre_lim);
    if (st.wd_run && next_st.wd_pre == st.wd_pre) begin
      next_st.wd_pre = tick ? 9'h000 : st.wd_pre + 9'h001;
      if (tick) begin
        next_st.wd_cnt = st.wd_cnt + 16'h0001;
      end
    end
    // Status follows the trip state; cleared only by counter change
    next_st.wd_status = st.wd_run && (next_st.wd_cnt == iew_pkg::WD_TRIP);
    // Sample all flags each cycle for the poll
    next_st.sample = src_flags(st);
    // Return pops the in-service level; depth wraps on a fourth nesting,
    // so the guard looks at the level, not at the depth
    if (reti_in && st.cur_lvl != 3'h0) begin
      next_st.depth   = st.depth - 2'h1;
      next_st.cur_lvl = mem_rdata;
    end
    // Acknowledge sequencer
    case (st.ack_st)
      iew_pkg::IEW_IDLE: begin
        if (st.ien_low[iew_pkg::POS_GLOBAL_EN] && best_ok &&
            ({1'b1, best_lvl} > st.cur_lvl || st.cur_lvl == 3'h0) &&
            !ack_block) begin
          next_st.ack_st  = iew_pkg::IEW_PEND;
          next_st.ack_src = best_src;
        end
      end
      iew_pkg::IEW_PEND: begin
        if (ack_block) begin
          next_st.ack_st = iew_pkg::IEW_IDLE;
        end else if (instr_end_in) begin
          next_st.ack_st = iew_pkg::IEW_ACK;
        end
      end
      iew_pkg::IEW_ACK: begin
        a = st.ack_src;
        next_st.lcall   = 1'b1;
        next_st.ack_st  = iew_pkg::IEW_IDLE;
        mem_wr          = 1'b1;
        next_st.depth   = st.depth + 2'h1;
        next_st.cur_lvl = {1'b1, src_level(a, st.prio0, st.prio1)};
        // Hardware clears edge and timer flags on vectoring
        case (a)
          4'h0: next_st.timer_and_ext_irq_control_flags[iew_pkg::POS_XA_FLAG] = 1'b0;
          4'h1: next_st.timer_and_ext_irq_control_flags[iew_pkg::POS_TA_OVF] = 1'b0;
          4'h2: next_st.timer_and_ext_irq_control_flags[iew_pkg::POS_XB_FLAG] = 1'b0;
          4'h3: next_st.timer_and_ext_irq_control_flags[iew_pkg::POS_TB_OVF] = 1'b0;
          4'h4, 4'h5: ;
          default: next_st.ext_flags[3'(a - 4'h6)] = 1'b0;
        endcase
      end
      default: next_st.ack_st = iew_pkg::IEW_IDLE;
    endcase
    // Flag set events after the vectoring clear, so a new event is never lost
    if (timer_a_ovf_in) next_st.timer_and_ext_irq_control_flags[iew_pkg::POS_TA_OVF] = 1'b1;
    if (timer_b_ovf_in) next_st.timer_and_ext_irq_control_flags[iew_pkg::POS_TB_OVF] = 1'b1;
    if (serial_a_irq_in) next_st.ser_flags[0] = 1'b1;
    if (serial_b_irq_in) next_st.ser_flags[1] = 1'b1;
    // Type bit: one means falling edge, zero means low level
    if (st.timer_and_ext_irq_control_flags[iew_pkg::POS_XA_TYPE] ? (st.ext_ab_last[0] && !ext_line_a_b_in)
                                             : !ext_line_a_b_in) begin
      next_st.timer_and_ext_irq_control_flags[iew_pkg::POS_XA_FLAG] = 1'b1;
    end
    if (st.timer_and_ext_irq_control_flags[iew_pkg::POS_XB_TYPE] ? (st.ext_ab_last[1] && !ext_line_b_b_in)
                                             : !ext_line_b_b_in) begin
      next_st.timer_and_ext_irq_control_flags[iew_pkg::POS_XB_FLAG] = 1'b1;
    end
    next_st.ext_flags = next_st.ext_flags | (st.ext_cg_last & ~ext_line_cg_in);
    // Register reads
    case (sfr_addr_in)
      iew_pkg::ADDR_IEN_LOW:   next_st.rdata = st.ien_low | {1'b0, |st.refresh_cnt, 6'h00};
      iew_pkg::ADDR_IEN_HIGH:  next_st.rdata = st.ien_high | {1'b0, |st.start_cnt, 6'h00};
      iew_pkg::ADDR_IEN_EXTRA: next_st.rdata = st.ien_extra;
      iew_pkg::ADDR_PRIO_ZERO: next_st.rdata = {1'b0, st.wd_status, st.prio0};
      iew_pkg::ADDR_PRIO_ONE:  next_st.rdata = {2'h0, st.prio1};
      iew_pkg::ADDR_TIMER_AND_EXT_IRQ_CONTROL_REG:  next_st.rdata = st.timer_and_ext_irq_control_flags;
      iew_pkg::ADDR_IRQ_REQ:   next_st.rdata = {2'h0, st.ext_flags, 1'b0};
      iew_pkg::ADDR_WD_RELOAD: next_st.rdata = st.wd_reload;
      default:                 next_st.rdata = 8'h00;
    endcase
    if (!sfr_rd_in) next_st.rdata = st.rdata;
  end

  // State register; clock enable freezes all state
  always_ff @(posedge clk_sys_in or negedge rst_s) begin
    if (!rst_s) begin
      st <= '0;
    end else if (clk_en_in) begin
      st <= next_st;
    end
  end

  // Stack of interrupted levels
  iew_prio_mem u_stack (
    .clk_in      (clk_sys_in),
    .en_in       (clk_en_in),
    .wr_in       (mem_wr),
    .wr_addr_in  (mem_waddr),
    .wr_data_in  (mem_wdata),
    .rd_addr_in  (st.depth - 2'h1),
    .rd_data_out (mem_rdata)
  );

  // Outputs from state flops
  assign sfr_rdata_out    = st.rdata;
  assign lcall_out        = st.lcall;
  assign lcall_src_out    = st.ack_src;
  assign wd_reset_req_out = st.wd_status;
  assign wd_count_out     = st.wd_cnt;

  refresh_life_a: assert property (@(posedge clk_sys_in) disable iff (!rst_s)
    (clk_en_in && sfr_wr_in && sfr_addr_in == iew_pkg::ADDR_IEN_LOW &&
     sfr_wdata_in[iew_pkg::POS_WD_REFRESH])
    |=> st.refresh_cnt == 4'(iew_pkg::FLAG_LIFE_CYC))
    else $error("refresh flag life wrong");
  start_run_a: assert property (@(posedge clk_sys_in) disable iff (!rst_s)
    st.wd_run |=> st.wd_run)
    else $error("watchdog stopped");
  status_trip_a: assert property (@(posedge clk_sys_in) disable iff (!rst_s)
    st.wd_status |-> st.wd_cnt == iew_pkg::WD_TRIP)
    else $error("status without trip");
  global_block_a: assert property (@(posedge clk_sys_in) disable iff (!rst_s)
    (st.ack_st == iew_pkg::IEW_IDLE && !st.ien_low[iew_pkg::POS_GLOBAL_EN])
    |=> st.ack_st == iew_pkg::IEW_IDLE)
    else $error("ack with global disable");
  lcall_pulse_a: assert property (@(posedge clk_sys_in) disable iff (!rst_s)
    (clk_en_in && lcall_out) |=> !lcall_out)
    else $error("lcall not a pulse");
  ack_follows_a: assert property (@(posedge clk_sys_in) disable iff (!rst_s)
    (clk_en_in && st.ack_st == iew_pkg::IEW_ACK) |=> lcall_out)
    else $error("ack without lcall");
  reti_hold_a: assert property (@(posedge clk_sys_in) disable iff (!rst_s)
    (clk_en_in && reti_in && st.ack_st == iew_pkg::IEW_PEND) |=> st.ack_st == iew_pkg::IEW_IDLE)
    else $error("ack during return");
  start_life_a: assert property (@(posedge clk_sys_in) disable iff (!rst_s)
    (st.start_cnt == 4'h1 && clk_en_in && !sfr_wr_in) |=> st.start_cnt == 4'h0)
    else $error("start flag stuck");
endmodule

// file: test_interrupt_enable_and_watchdog_refresh.sv
// Self-checking testbench of the interrupt enable and watchdog block
`timescale 1ns/100ps
module test_interrupt_enable_and_watchdog_refresh;
  localparam time DLY = 1;
  logic        clk_sys_in, rst_b_in, sfr_wr_in, sfr_rd_in, instr_end_in, reti_in;
  logic [7:0]  sfr_addr_in, sfr_wdata_in, sfr_rdata_out, rd;
  logic        lcall_out, timer_a_ovf_in, timer_b_ovf_in, serial_a_irq_in, serial_b_irq_in;
  logic        ext_line_a_b_in, ext_line_b_b_in, wd_reset_req_out, got;
  logic [4:0]  ext_line_cg_in;
  logic [3:0]  lcall_src_out, src;
  logic [15:0] wd_count_out;
  int          n_fail, n_checks, cyc;
  // Address, value written, value read back
  logic [23:0] rows [6] = '{
    {iew_pkg::ADDR_WD_RELOAD, 8'hA5, 8'hA5}, {iew_pkg::ADDR_IEN_EXTRA, 8'h01, 8'h01},
    {iew_pkg::ADDR_IEN_HIGH, 8'h3E, 8'h3E},  {iew_pkg::ADDR_IEN_LOW, 8'h1F, 8'h1F},
    {iew_pkg::ADDR_TIMER_AND_EXT_IRQ_CONTROL_REG, 8'h05, 8'h05},  {8'h00, 8'hFF, 8'h00}};

  iew_top uut (
    .clk_sys_in(clk_sys_in), .clk_en_in(1'b1), .rst_b_in(rst_b_in),
    .sfr_wr_in(sfr_wr_in), .sfr_rd_in(sfr_rd_in), .sfr_addr_in(sfr_addr_in),
    .sfr_wdata_in(sfr_wdata_in), .sfr_rdata_out(sfr_rdata_out),
    .instr_end_in(instr_end_in), .reti_in(reti_in), .lcall_out(lcall_out),
    .lcall_src_out(lcall_src_out), .timer_a_ovf_in(timer_a_ovf_in),
    .timer_b_ovf_in(timer_b_ovf_in), .serial_a_irq_in(serial_a_irq_in),
    .serial_b_irq_in(serial_b_irq_in), .ext_line_a_b_in(ext_line_a_b_in),
    .ext_line_b_b_in(ext_line_b_b_in), .ext_line_cg_in(ext_line_cg_in),
    .wd_reset_req_out(wd_reset_req_out), .wd_count_out(wd_count_out));

  iew_core_model core (
    .clk_in(clk_sys_in), .rst_b_in(rst_b_in), .gap_in(4'h2), .lcall_in(lcall_out),
    .instr_end_out(instr_end_in), .reti_out(reti_in));

  // 250 MHz clock
  initial begin
    clk_sys_in = 1'b0;
    forever #2 clk_sys_in = ~clk_sys_in;
  end

  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    n_checks++;
    if (seen !== exp) begin
      n_fail++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic summarize;
    if (n_fail == 0 && n_checks > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask

  task automatic sfr_w(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk_sys_in); #DLY;
    sfr_wr_in = 1'b1; sfr_addr_in = a; sfr_wdata_in = d;
    @(posedge clk_sys_in); #DLY;
    sfr_wr_in = 1'b0;
  endtask

  task automatic sfr_r(input logic [7:0] a, output logic [7:0] d);
    @(posedge clk_sys_in); #DLY;
    sfr_rd_in = 1'b1; sfr_addr_in = a;
    @(posedge clk_sys_in); #DLY;
    sfr_rd_in = 1'b0; d = sfr_rdata_out;
  endtask

  // Bounded wait for a forced call; the pulse lasts one cycle
  task automatic wait_call(input int lim, output logic hit, output logic [3:0] s);
    hit = 1'b0; s = 4'h0;
    for (int i = 0; i < lim && !hit; i++) begin
      @(posedge clk_sys_in); #DLY;
      if (lcall_out === 1'b1) begin hit = 1'b1; s = lcall_src_out; end
    end
  endtask

  // Cycles between two steps of the watchdog count
  task automatic tick_gap(output int n);
    logic [15:0] v;
    for (int k = 0; k < 2; k++) begin
      v = wd_count_out; n = 0;
      while (wd_count_out === v && n < 1000) begin @(posedge clk_sys_in); #DLY; n++; end
    end
  endtask

  // Refresh flag first, start flag right after, well inside the 12-cycle span
  task automatic wd_kick(input logic [7:0] rel);
    sfr_w(iew_pkg::ADDR_WD_RELOAD, rel);
    sfr_w(iew_pkg::ADDR_IEN_LOW, 8'h40);
    sfr_w(iew_pkg::ADDR_IEN_HIGH, 8'h40);
  endtask

  // Hang guard well above the longest expected run
  always @(posedge clk_sys_in) begin
    cyc++;
    if (cyc == 20000) begin n_fail++; summarize(); end
  end

  initial begin
    int n;
    n_fail = 0; n_checks = 0; cyc = 0; rst_b_in = 1'b0;
    {sfr_wr_in, sfr_rd_in, timer_a_ovf_in, timer_b_ovf_in} = 4'h0;
    {serial_a_irq_in, serial_b_irq_in} = 2'h0;
    sfr_addr_in = 8'h00; sfr_wdata_in = 8'h00;
    ext_line_a_b_in = 1'b1; ext_line_b_b_in = 1'b1; ext_line_cg_in = 5'h1F;
    repeat (10) @(posedge clk_sys_in);
    #DLY rst_b_in = 1'b1;
    repeat (3) @(posedge clk_sys_in);
    // Registers come up cleared
    foreach (rows[i]) begin sfr_r(rows[i][23:16], rd); check(16'(rd), 16'h0); end
    // Ordinary write and read back, unmapped place ignored
    foreach (rows[i]) begin
      sfr_w(rows[i][23:16], rows[i][15:8]);
      sfr_r(rows[i][23:16], rd);
      check(16'(rd), 16'(rows[i][7:0]));
    end
    sfr_w(iew_pkg::ADDR_TIMER_AND_EXT_IRQ_CONTROL_REG, 8'h00);
    sfr_w(iew_pkg::ADDR_IEN_HIGH, 8'h00);
    sfr_w(iew_pkg::ADDR_IEN_EXTRA, 8'h00);
    // Flag sets while global enable is off, and no call follows
    sfr_w(iew_pkg::ADDR_IEN_LOW, 8'h02);
    @(posedge clk_sys_in); #DLY timer_a_ovf_in = 1'b1;
    @(posedge clk_sys_in); #DLY timer_a_ovf_in = 1'b0;
    sfr_r(iew_pkg::ADDR_TIMER_AND_EXT_IRQ_CONTROL_REG, rd);
    check(16'(rd[iew_pkg::POS_TA_OVF]), 16'h1);
    wait_call(40, got, src);
    check(16'(got), 16'h0);
    // Global enable on: forced call for timer a, then flag cleared
    sfr_w(iew_pkg::ADDR_IEN_LOW, 8'h82);
    wait_call(40, got, src);
    check({11'h0, got, src}, 16'h0011);
    sfr_r(iew_pkg::ADDR_TIMER_AND_EXT_IRQ_CONTROL_REG, rd);
    check(16'(rd[iew_pkg::POS_TA_OVF]), 16'h0);
    repeat (30) @(posedge clk_sys_in);
    // Falling edge on line c reaches the core through its own enable
    sfr_w(iew_pkg::ADDR_IEN_HIGH, 8'h02);
    ext_line_cg_in = 5'h1E;
    wait_call(40, got, src);
    check({11'h0, got, src}, 16'h0016);
    ext_line_cg_in = 5'h1F;
    repeat (30) @(posedge clk_sys_in);
    // Slow prescaler: high byte loaded, start consumes the refresh flag, start flag drops after 12 cycles
    wd_kick(8'h85);
    check(16'(wd_count_out[14:8]), 16'h05);
    sfr_r(iew_pkg::ADDR_IEN_HIGH, rd);
    check(16'(rd[iew_pkg::POS_WD_START]), 16'h1);
    repeat (14) @(posedge clk_sys_in);
    sfr_r(iew_pkg::ADDR_IEN_LOW, rd);
    check(16'(rd[iew_pkg::POS_WD_REFRESH]), 16'h0);
    sfr_r(iew_pkg::ADDR_IEN_HIGH, rd);
    check(16'(rd[iew_pkg::POS_WD_START]), 16'h0);
    tick_gap(n);
    check(16'(n), 16'(iew_pkg::WD_TICK_SLOW));
    // Fast rate reloaded near the trip point; it cannot be stopped
    wd_kick(8'h7C);
    check(16'(wd_count_out[14:8]), 16'h7C);
    sfr_w(iew_pkg::ADDR_IEN_HIGH, 8'h00);
    tick_gap(n);
    check(16'(n), 16'(iew_pkg::WD_TICK_FAST));
    n = 0;
    while (wd_reset_req_out !== 1'b1 && n < 7000) begin @(posedge clk_sys_in); #DLY; n++; end
    check(wd_count_out, iew_pkg::WD_TRIP);
    sfr_r(iew_pkg::ADDR_PRIO_ZERO, rd);
    check(16'(rd[iew_pkg::POS_WD_STATUS]), 16'h1);
    summarize();
  end
endmodule
